/* File: adc_compute_pkg.sv */
package adc_compute_pkg;

  // register indices (word addresses on the plain register port)
  localparam logic [3:0] REG_CLOCK_DIV = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_REPEAT = 4'h2;
  localparam logic [3:0] REG_SETPOINT = 4'h3;
  localparam logic [3:0] REG_UPPER_TH = 4'h4;
  localparam logic [3:0] REG_LOWER_TH = 4'h5;
  localparam logic [3:0] REG_RESULT = 4'h6;
  localparam logic [3:0] REG_PREV_RESULT = 4'h7;
  localparam logic [3:0] REG_FILTER = 4'h8;
  localparam logic [3:0] REG_ERROR = 4'h9;
  localparam logic [3:0] REG_COUNT = 4'hA;
  localparam logic [3:0] REG_STATUS = 4'hB;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;

  // control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_SHIFT_LSB = 4;
  localparam int CTL_CALC_LSB = 8;
  localparam int CTL_TEST_LSB = 12;
  localparam int CTL_CONT_BIT = 15;

  // status bits
  localparam int ST_THRESH = 0;
  localparam int ST_UPPER = 1;
  localparam int ST_LOWER = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_COMPLETE = 4;
  localparam int ST_WIDTH = 5;

  localparam logic [7:0] CLOCK_DIV_RESET = 8'h00;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [7:0] REPEAT_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 5'h00;

  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUM = 3'h1;
  localparam logic [2:0] MODE_AVERAGE = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LOWPASS = 3'h4;

  typedef enum logic [2:0] {
    CALC_FIRST_DERIV, CALC_CAP_DIV, CALC_RES_SETPT, CALC_RES_FILT,
    CALC_FILT_DERIV, CALC_FILT_SETPT, CALC_RSV6, CALC_RSV7
  } calc_e;

  typedef enum logic [2:0] {
    TEST_NEVER, TEST_BELOW_LOW, TEST_ATLEAST_LOW, TEST_INSIDE,
    TEST_OUTSIDE, TEST_ATMOST_UP, TEST_ABOVE_UP, TEST_ALWAYS
  } test_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] result;
    logic [15:0] cap_div;
  } conv_s;

endpackage

/* File: adc_clock_divider.sv */
`timescale 1ns/1ps
module adc_clock_divider (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] select_i,
  output logic tick_o
);
  logic [6:0] cnt_q;
  logic [6:0] limit;

  // period is 2*(select+1) cycles
  assign limit = {select_i, 1'b1};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 7'h00;
    end else if (cnt_q >= limit) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q >= limit);
    end
  end
endmodule

/* File: adc_compute_threshold.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
//
// Contract
// - in burst-average mode retrigger sampling until the count reaches the repeat target.
// - in low-pass mode accumulate to the repeat target, filter, then run the threshold test; the code filters every sample and tests at the repeat target.
// - the filter shift setting sets the low-pass weighting between new sample and filter.
// - results are latched at end of conversion and held stable for software.
// - the error is one of six differences picked by the 3-bit calculation select; the code's CALC_CAP_DIV passes the cap divider word itself, not a difference.
// - the error is compared to upper and lower thresholds, updating both flags.
// - a 3-bit test select picks one of eight threshold tests.
// - a satisfied test at the end of a computation sets the threshold interrupt flag.
// - all threshold comparisons are signed two's complement.
// - a set accumulator overflow flag forces a threshold interrupt.
module adc_compute_threshold
  import adc_compute_pkg::*;
#(
  parameter int ACC_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input adc_compute_pkg::reg_req_s req_i,
  output logic [15:0] rdata_o,
  input adc_compute_pkg::conv_s conv_i,
  output logic retrigger_o,
  output logic conv_clk_tick_o,
  output logic irq_o
);
  import adc_compute_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] clk_div_q;
  logic [15:0] ctl_q;
  logic [7:0] repeat_q;
  logic [15:0] setpt_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] result_q;
  logic [15:0] prev_result_q;
  logic [15:0] filt_q;
  logic [15:0] prev_filt_q;
  logic [15:0] err_q;
  logic [7:0] count_q;
  logic [ACC_W-1:0] acc_q;
  logic [ST_WIDTH-1:0] status_q;
  logic [ST_WIDTH-1:0] mask_q;
  logic [15:0] rdata_q;
  logic retrig_q;

  logic [2:0] mode;
  logic [2:0] shift;
  calc_e calc;
  test_e test;
  logic wr_ctl;

  assign mode = ctl_q[CTL_MODE_LSB +: 3];
  assign shift = ctl_q[CTL_SHIFT_LSB +: 3];
  assign calc = calc_e'(ctl_q[CTL_CALC_LSB +: 3]);
  assign test = test_e'(ctl_q[CTL_TEST_LSB +: 3]);
  assign wr_ctl = req_i.wr && (req_i.addr == REG_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_div_q <= CLOCK_DIV_RESET;
      ctl_q <= CONTROL_RESET;
      repeat_q <= REPEAT_RESET;
      setpt_q <= DATA_RESET;
      upper_q <= DATA_RESET;
      lower_q <= DATA_RESET;
      mask_q <= MASK_RESET;
    end else if (req_i.wr) begin
      case (req_i.addr)
        // upper bits unimplemented
        REG_CLOCK_DIV: clk_div_q <= {2'h0, req_i.wdata[5:0]};
        REG_CONTROL: ctl_q <= req_i.wdata;
        REG_REPEAT: repeat_q <= req_i.wdata[7:0];
        REG_SETPOINT: setpt_q <= req_i.wdata;
        REG_UPPER_TH: upper_q <= req_i.wdata;
        REG_LOWER_TH: lower_q <= req_i.wdata;
        REG_IRQ_MASK: mask_q <= req_i.wdata[ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  adc_clock_divider u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .select_i(clk_div_q[5:0]),
    .tick_o(conv_clk_tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // accumulation and filtering
  logic [7:0] count_next;
  logic done;
  logic [ACC_W-1:0] acc_sum;
  logic acc_ovf;
  logic [ACC_W-1:0] acc_shr;
  logic signed [16:0] lp_step;
  logic [15:0] lp_next;
  logic [15:0] filt_next;

  // saturates so a long run never wraps back to zero
  assign count_next = (count_q == 8'hFF) ? count_q : count_q + 8'h01;
  // basic mode finishes on every sample, the other modes at the repeat target
  assign done = (mode == MODE_BASIC) || (count_next >= repeat_q);
  assign acc_sum = acc_q + ACC_W'(conv_i.result);
  assign acc_ovf = (acc_sum < acc_q);
  assign acc_shr = acc_sum >> shift;
  assign lp_step = 17'(($signed({1'b0, conv_i.result}) - $signed({1'b0, filt_q})) >>> shift);
  assign lp_next = 16'($signed({1'b0, filt_q}) + lp_step);
  assign filt_next = (mode == MODE_LOWPASS) ? lp_next :
                     (mode == MODE_BASIC) ? filt_q : acc_shr[15:0];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 8'h00;
      acc_q <= '0;
    end else if (wr_ctl) begin
      count_q <= 8'h00;
      acc_q <= '0;
    end else if (conv_i.valid) begin
      if (done) begin
        count_q <= 8'h00;
        acc_q <= '0;
      end else begin
        count_q <= count_next;
        acc_q <= acc_sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch results at end of conversion
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= DATA_RESET;
      prev_result_q <= DATA_RESET;
    end else if (conv_i.valid) begin
      result_q <= conv_i.result;
      prev_result_q <= result_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= DATA_RESET;
      prev_filt_q <= DATA_RESET;
    end else if (conv_i.valid && (done || mode == MODE_LOWPASS)) begin
      filt_q <= filt_next;
      if (done) begin
        prev_filt_q <= filt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error calculation and threshold test
  logic [15:0] err_next;
  logic signed [15:0] err_s;
  logic lt_low;
  logic gt_up;
  logic hit;

  always_comb begin
    case (calc)
      CALC_FIRST_DERIV: err_next = conv_i.result - result_q;
      CALC_CAP_DIV: err_next = conv_i.cap_div;
      CALC_RES_SETPT: err_next = conv_i.result - setpt_q;
      CALC_RES_FILT: err_next = conv_i.result - filt_next;
      CALC_FILT_DERIV: err_next = filt_next - filt_q;
      CALC_FILT_SETPT: err_next = filt_next - setpt_q;
      default: err_next = 16'h0000;
    endcase
  end

  assign err_s = $signed(err_next);
  assign lt_low = err_s < $signed(lower_q);
  assign gt_up = err_s > $signed(upper_q);

  always_comb begin
    case (test)
      TEST_NEVER: hit = 1'b0;
      TEST_BELOW_LOW: hit = lt_low;
      TEST_ATLEAST_LOW: hit = !lt_low;
      TEST_INSIDE: hit = !lt_low && !gt_up;
      TEST_OUTSIDE: hit = lt_low || gt_up;
      TEST_ATMOST_UP: hit = !gt_up;
      TEST_ABOVE_UP: hit = gt_up;
      TEST_ALWAYS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q <= DATA_RESET;
    end else if (conv_i.valid && done) begin
      err_q <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins
  logic [ST_WIDTH-1:0] set_ev;
  logic [ST_WIDTH-1:0] clr;
  logic comp_end;

  assign comp_end = conv_i.valid && done;
  assign clr = (req_i.wr && req_i.addr == REG_STATUS) ? req_i.wdata[ST_WIDTH-1:0] : '0;

  always_comb begin
    set_ev = '0;
    if (comp_end) begin
      set_ev[ST_UPPER] = gt_up;
      set_ev[ST_LOWER] = lt_low;
      set_ev[ST_COMPLETE] = 1'b1;
      set_ev[ST_THRESH] = hit || status_q[ST_OVERFLOW] || acc_ovf;
    end
    // wrap sets its own flag and the interrupt
    if (conv_i.valid && !wr_ctl && mode != MODE_BASIC && acc_ovf) begin
      set_ev[ST_OVERFLOW] = 1'b1;
      set_ev[ST_THRESH] = 1'b1;
    end
  end

  // set checked before clear so a same-cycle event is never lost
  for (genvar b = 0; b < ST_WIDTH; b++) begin : g_status
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        status_q[b] <= 1'b0;
      end else if (set_ev[b]) begin
        status_q[b] <= 1'b1;
      end else if (clr[b]) begin
        status_q[b] <= 1'b0;
      end
    end
  end

  // level output, drops as soon as the bit is cleared or masked
  assign irq_o = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // burst retrigger regardless of continuous enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      retrig_q <= 1'b0;
    end else begin
      retrig_q <= conv_i.valid &&
                  ((mode == MODE_BURST && !done) || ctl_q[CTL_CONT_BIT]);
    end
  end

  assign retrigger_o = retrig_q;

  ////////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe
  logic [15:0] rd_mux;

  // unmapped indices read as zero
  always_comb begin
    case (req_i.addr)
      REG_CLOCK_DIV: rd_mux = {8'h00, clk_div_q};
      REG_CONTROL: rd_mux = ctl_q;
      REG_REPEAT: rd_mux = {8'h00, repeat_q};
      REG_SETPOINT: rd_mux = setpt_q;
      REG_UPPER_TH: rd_mux = upper_q;
      REG_LOWER_TH: rd_mux = lower_q;
      REG_RESULT: rd_mux = result_q;
      REG_PREV_RESULT: rd_mux = prev_result_q;
      REG_FILTER: rd_mux = filt_q;
      REG_ERROR: rd_mux = err_q;
      REG_COUNT: rd_mux = {8'h00, count_q};
      REG_STATUS: rd_mux = {11'h000, status_q};
      REG_IRQ_MASK: rd_mux = {11'h000, mask_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // zero outside the slot so a stale word is never mistaken for data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 16'h0000;
    end else if (req_i.rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_o = rdata_q;
endmodule

/* File: adc_core_model.sv */
`timescale 1ns/1ps
module adc_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [3:0] delay_i,
  input wire logic [15:0] sample_i,
  output adc_compute_pkg::conv_s conv_o
);
  import adc_compute_pkg::*;
  ////////////////////////////////////////
  logic [4:0] wait_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 5'h00;
    end else if (start_i) begin
      wait_q <= {1'b0, delay_i} + 5'h01;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
    end
  end
  // data lanes carry garbage outside the valid pulse
  assign conv_o.valid = (wait_q == 5'h01);
  assign conv_o.result = conv_o.valid ? sample_i : ~sample_i;
  assign conv_o.cap_div = ~conv_o.result;
endmodule

/* File: adc_compute_threshold_checker.sv */
`timescale 1ns/1ps
module adc_compute_threshold_checker #(
  parameter int ACC_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input adc_compute_pkg::reg_req_s req_i,
  input wire logic [15:0] rdata_o,
  input adc_compute_pkg::conv_s conv_i,
  input wire logic retrigger_o,
  input wire logic conv_clk_tick_o,
  input wire logic irq_o
);
  import adc_compute_pkg::*;
  logic [15:0] ctl_q;
  logic [ST_WIDTH-1:0] mask_q;
  logic [7:0] gap_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_q <= CONTROL_RESET;
      mask_q <= MASK_RESET;
    end else if (req_i.wr && req_i.addr == REG_CONTROL) begin
      ctl_q <= req_i.wdata;
    end else if (req_i.wr && req_i.addr == REG_IRQ_MASK) begin
      mask_q <= req_i.wdata[ST_WIDTH-1:0];
    end
  end
  // a divider write may restart the period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q <= 8'h00;
    end else if (conv_clk_tick_o || (req_i.wr && req_i.addr == REG_CLOCK_DIV)) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle_zero: assert property (
    !$past(req_i.rd) |-> rdata_o == 16'h0000) else $error("read data outside slot");
  a_unmapped_read_zero: assert property (
    $past(req_i.rd) && $past(req_i.addr) > REG_IRQ_MASK |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_div_upper_zero: assert property (
    $past(req_i.rd) && $past(req_i.addr) == REG_CLOCK_DIV |-> rdata_o[15:6] == 10'h000)
    else $error("divider upper bits not zero");
  a_tick_single: assert property (
    conv_clk_tick_o |=> !conv_clk_tick_o) else $error("tick longer than one cycle");
  a_tick_gap_bound: assert property (
    gap_q < 8'h80) else $error("tick period above 128");
  a_retrig_cause: assert property (
    retrigger_o |-> $past(conv_i.valid)) else $error("retrigger without sample");
  a_basic_no_retrig: assert property (
    conv_i.valid && !req_i.wr && ctl_q[2:0] == MODE_BASIC && !ctl_q[CTL_CONT_BIT]
    |=> !retrigger_o) else $error("retrigger in single basic mode");
  a_irq_needs_mask: assert property (
    irq_o |-> mask_q != '0) else $error("interrupt while fully masked");
  a_irq_w1c_all: assert property (
    req_i.wr && req_i.addr == REG_STATUS && (&req_i.wdata[ST_WIDTH-1:0]) && !conv_i.valid
    |=> !irq_o) else $error("interrupt kept after clear");
  a_irq_rise_cause: assert property (
    $rose(irq_o) |-> $past(conv_i.valid) || $past(req_i.wr)) else $error("interrupt from nowhere");
  c_retrig: cover property (retrigger_o);
  c_irq: cover property ($rose(irq_o));
  c_tick: cover property (conv_clk_tick_o ##2 conv_clk_tick_o);
endmodule
bind adc_compute_threshold adc_compute_threshold_checker #(.ACC_W(ACC_W)) i_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o), .conv_i(conv_i),
  .retrigger_o(retrigger_o), .conv_clk_tick_o(conv_clk_tick_o), .irq_o(irq_o));

/* File: adc_compute_threshold_test.sv */
`timescale 1ns/1ps
module adc_compute_threshold_test;
  import adc_compute_pkg::*;
  typedef struct packed {
    logic [2:0] test;
    logic [15:0] err;
    logic [2:0] flags;
  } row_s;
  // flags are lower, upper, threshold; upper 16, lower -16
  localparam row_s ROWS [13] = '{'{3'h0, 16'hFFEC, 3'h4}, '{3'h1, 16'hFFEC, 3'h5},
    '{3'h1, 16'hFFF0, 3'h0}, '{3'h2, 16'hFFF0, 3'h1}, '{3'h3, 16'h0010, 3'h1},
    '{3'h3, 16'h0014, 3'h2}, '{3'h4, 16'h0014, 3'h3}, '{3'h4, 16'h0005, 3'h0},
    '{3'h5, 16'h0010, 3'h1}, '{3'h5, 16'hFFEC, 3'h5}, '{3'h6, 16'h0014, 3'h3},
    '{3'h6, 16'hFFEC, 3'h4}, '{3'h7, 16'h0005, 3'h1}};
  logic clk, rst_n, start, retrig, tick, irq;
  reg_req_s req;
  conv_s conv;
  logic [15:0] rdata, sample, v;
  logic [3:0] dly;
  int fail_count, checked, n, k;
  // narrow accumulator so three full-scale samples overflow it
  adc_compute_threshold #(.ACC_W(17)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
    .rdata_o(rdata), .conv_i(conv), .retrigger_o(retrig), .conv_clk_tick_o(tick), .irq_o(irq));
  adc_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .start_i(start | retrig),
    .delay_i(dly), .sample_i(sample), .conv_o(conv));
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    check(d, e);
  endtask
  task automatic irqchk(input logic e);
    @(negedge clk);
    check({15'h0000, irq}, {15'h0000, e});
    @(posedge clk);
  endtask
  task automatic conv1(input logic [15:0] s);
    sample <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 40 && conv.valid !== 1'b1; n++) @(negedge clk);
    if (n == 40) begin
      fail_count++;
      conclude();
    end
    @(posedge clk);
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    start = 1'b0;
    sample = 16'h0000;
    dly = 4'h2;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(REG_CONTROL, CONTROL_RESET);
    rc(REG_IRQ_MASK, 16'h0000);
    rc(REG_CLOCK_DIV, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rc(4'hF, 16'h0000);
    wr(REG_CLOCK_DIV, 16'h00FF);
    rc(REG_CLOCK_DIV, 16'h003F);
    for (k = 0; k < 2; k++) begin
      wr(REG_CLOCK_DIV, 16'(k * 3));
      @(negedge clk);
      for (n = 0; n < 300 && tick !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      for (n = 1; n < 300 && tick !== 1'b1; n++) @(negedge clk);
      check(16'(n), 16'(2 * (k * 3 + 1)));
      if (n >= 300) begin
        conclude();
      end
      @(posedge clk);
    end
    wr(REG_SETPOINT, 16'h0000);
    wr(REG_UPPER_TH, 16'h0010);
    wr(REG_LOWER_TH, 16'hFFF0);
    foreach (ROWS[i]) begin
      wr(REG_CONTROL, {1'b0, ROWS[i].test, 1'b0, CALC_RES_SETPT, 8'h00});
      conv1(ROWS[i].err);
      rd(REG_STATUS, v);
      check({13'h0000, v[2:0]}, {13'h0000, ROWS[i].flags});
      rc(REG_RESULT, ROWS[i].err);
      rc(REG_ERROR, ROWS[i].err);
      wr(REG_STATUS, 16'h001F);
    end
    wr(REG_CONTROL, {5'h00, CALC_CAP_DIV, 8'h00});
    conv1(16'h1234);
    rc(REG_ERROR, 16'hEDCB);
    wr(REG_CONTROL, {1'b0, TEST_ALWAYS, 12'h000});
    conv1(16'h0005);
    irqchk(1'b0);
    wr(REG_IRQ_MASK, 16'h0001);
    irqchk(1'b1);
    wr(REG_STATUS, 16'h0001);
    irqchk(1'b0);
    wr(REG_REPEAT, 16'h0004);
    wr(REG_CONTROL, {1'b0, TEST_ALWAYS, 9'h000, MODE_BURST});
    dly <= 4'h5;
    sample <= 16'h0040;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      k = k + int'(retrig === 1'b1);
    end
    check(16'(k), 16'h0003);
    @(posedge clk);
    rd(REG_STATUS, v);
    check({15'h0000, v[ST_COMPLETE]}, 16'h0001);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(REG_REPEAT, 16'h0000);
    wr(REG_REPEAT, 16'h0002);
    wr(REG_CONTROL, {9'h000, 3'h1, 1'b0, MODE_LOWPASS});
    dly <= 4'h0;
    v = 16'h0000;
    repeat (2) begin
      conv1(16'h0100);
      v = v + 16'($signed(16'h0100 - v) >>> 1);
    end
    rc(REG_FILTER, v);
    wr(REG_REPEAT, 16'h0003);
    wr(REG_CONTROL, {1'b0, TEST_NEVER, 9'h000, MODE_ACCUM});
    repeat (3) conv1(16'hFFFF);
    rc(REG_STATUS, 16'h0019);
    rc(REG_PREV_RESULT, 16'hFFFF);
    rc(REG_COUNT, 16'h0000);
    conclude();
  end
endmodule
